// File: rtl/aidc_pkg.sv
// package: register map, field positions and decode result type
package aidc_pkg;
  // control-bus offsets
  localparam logic [7:0] ENTRY_OFFS = 8'h04;
  localparam logic [7:0] CTRL_OFFS  = 8'h05;
  localparam int unsigned NUM_ENTRIES = 16;
  // entry fields, vector index = 31 - printed bit
  localparam int unsigned E_PRIMARY = 31;
  localparam int unsigned E_EXT_HI  = 30;
  localparam int unsigned E_EXT_LO  = 20;
  localparam int unsigned E_PRIV    = 19;
  localparam int unsigned E_SRC1    = 18;
  localparam int unsigned E_SRC2    = 17;
  localparam int unsigned E_TGT_WR  = 16;
  localparam int unsigned E_CR_EN   = 15;
  localparam int unsigned E_CRF_HI  = 13;
  localparam int unsigned E_CRF_LO  = 11;
  localparam int unsigned E_REG_HI  = 9;
  localparam int unsigned E_REG_LO  = 6;
  localparam int unsigned E_TYPE_HI = 5;
  localparam int unsigned E_TYPE_LO = 4;
  localparam int unsigned E_WILD    = 1;
  localparam int unsigned E_EN      = 0;
  localparam logic [31:0] ENTRY_MASK = 32'hFFFF_BBF3;
  // execution types
  localparam logic [1:0] TYPE_EARLY = 2'h0;
  localparam logic [1:0] TYPE_LATE  = 2'h1;
  localparam logic [1:0] TYPE_AUTO  = 2'h2;
  localparam logic [1:0] TYPE_PTR   = 2'h3;
  // primary opcodes selectable by an entry
  localparam logic [5:0] PRIM_OP0 = 6'h00;
  localparam logic [5:0] PRIM_OP4 = 6'h04;
  // control register fields, vector index = 31 - printed bit
  localparam int unsigned C_RESET    = 31;
  localparam int unsigned C_LDST_DIS = 26;
  localparam int unsigned C_UDI_DIS  = 25;
  localparam int unsigned C_UDI_LATE = 24;
  localparam int unsigned C_FP_DIS   = 23;
  localparam int unsigned C_FPC_HI   = 22;
  localparam int unsigned C_FPC_LO   = 17;
  localparam int unsigned C_FP_LATE  = 16;
  localparam int unsigned C_ST_WB    = 15;
  localparam int unsigned C_LDST_PRV = 14;
  localparam int unsigned C_ALIGN    = 11;
  localparam int unsigned C_LITTLE_ENDIAN_TRAP  = 10;
  localparam int unsigned C_BIG_ENDIAN_TRAP  = 9;
  localparam int unsigned C_ENABLE   = 0;
  localparam logic [31:0] CTRL_MASK  = 32'h07FF_CE01;

  // one decode answer
  typedef struct packed {
    logic        valid;
    logic        claimed;
    logic        udi_hit;
    logic        illegal;
    logic        unimplemented;
    logic        priv_violation;
    logic        endian_trap;
    logic        first_source_operand;
    logic        second_source_operand;
    logic        target_register;
    logic        condition_return_enable;
    logic [2:0]  condition_field_select;
    logic [1:0]  exec_type;
    logic [31:0] ldst_addr;
  } aidc_result_t;
endpackage : aidc_pkg

// File: rtl/aidc_decode_config.sv
// aux processor unit decode configuration and decode control
// Summary of operation
// - entry bit0 picks opcode 0/4, eleven-bit extended
// - privilege bit flags a privilege violation outside privileged mode
// - bits 13/14 request first/second source operands
// - bit 15 routes result to target register
// - bit 16 returns condition bits to field
// - type field selects early/late/autonomous/pointer
// - register number only used by pointer type
// - wildcard compares only extended bits 6..11
// - only enabled entries take part in matching
// - writing bit0 restores defaults, reads zero
// - bit5 blocks coprocessor load/store, illegal
// - bit6 blocks custom instructions, illegal
// - bit7 forces custom late confirm
// - bit8 blocks floating point, illegal
// - bits 9-14 disable fp classes, unimplemented
// - bit15 forces floating point late confirm
// - bit16 delays store permit past writeback
// - bit17 makes custom load/store privileged
// - bit20 forces natural alignment, no exception
// - bits 21/22 trap little/big endian storage
// - bit31 clear stops all decode flags and requests, exec_type still follows the entry
`timescale 1ns/10ps
`default_nettype none
module aidc_decode_config
  import aidc_pkg::*;
(
  input  wire logic                                core_clk_in,
  input  wire logic                                rst_in,
  // register bus
  input  wire logic [7:0]                          dcr_addr_in,
  input  wire logic                                dcr_read_in,
  input  wire logic                                dcr_write_in,
  input  wire logic [31:0]                         dcr_wdata_in,
  output logic [31:0]                              dcr_rdata_out,
  output logic                                     dcr_ack_out,
  // reset defaults
  input  wire logic [31:0]                         decode_control_tieoff_in,
  input  wire logic [aidc_pkg::NUM_ENTRIES-1:0][31:0] entry_tieoff_first_in,
  // instruction from the pipeline
  input  wire logic                                insn_valid_in,
  input  wire logic [31:0]                         insn_in,
  input  wire logic                                priv_mode_in,
  input  wire logic                                is_custom_ldst_in,
  input  wire logic                                is_fp_in,
  input  wire logic                                is_fp_ldst_in,
  input  wire logic [5:0]                          fp_class_in,
  input  wire logic [31:0]                         ldst_addr_in,
  input  wire logic [2:0]                          ldst_size_log2_in,
  input  wire logic                                little_endian_in,
  // store progress
  input  wire logic                                store_issue_in,
  input  wire logic                                store_passed_lwb_in,
  output aidc_pkg::aidc_result_t                   result_out,
  output logic                                     store_commit_permit_out
);
  import aidc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [NUM_ENTRIES-1:0][31:0] entry_r;
  logic [31:0]                  ctrl_r;
  logic [3:0]                   ptr_r;
  logic [31:0]                  rdata_r;
  logic                         ack_r;
  aidc_result_t                 result_r;
  logic                         permit_r;

  // bus decode
  wire sel_entry = dcr_addr_in == ENTRY_OFFS;
  wire sel_ctrl  = dcr_addr_in == CTRL_OFFS;
  wire wr_entry  = dcr_write_in && sel_entry;
  wire wr_ctrl   = dcr_write_in && sel_ctrl;
  wire [1:0] wr_type = dcr_wdata_in[E_TYPE_HI:E_TYPE_LO];
  // write of one to bit0 restores defaults
  wire soft_reset = wr_ctrl && dcr_wdata_in[C_RESET];
  // pointer-type write moves the pointer, not stored
  wire ptr_write  = wr_entry && (wr_type == TYPE_PTR);

  wire [31:0] rd_mux = sel_entry ? (entry_r[ptr_r] & ENTRY_MASK)
                     : sel_ctrl  ? (ctrl_r & CTRL_MASK) : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // register file: reset loads tie-offs, soft reset does the same
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || soft_reset)
    begin
      entry_r <= entry_tieoff_first_in;
      ctrl_r  <= decode_control_tieoff_in & CTRL_MASK;
      ptr_r   <= 4'h0;
    end
    else
    begin
      if (ptr_write)
        ptr_r <= dcr_wdata_in[E_REG_HI:E_REG_LO];
      else if (wr_entry)
        entry_r[ptr_r] <= dcr_wdata_in & ENTRY_MASK;
      if (wr_ctrl)
        ctrl_r <= dcr_wdata_in & CTRL_MASK;
    end
  end

  // bus answer one cycle after the strobe; other offsets are not ours
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r   <= (dcr_read_in || dcr_write_in) && (sel_entry || sel_ctrl);
      rdata_r <= dcr_read_in ? rd_mux : 32'h0000_0000;
    end
  end

  assign dcr_ack_out   = ack_r;
  assign dcr_rdata_out = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // per-entry opcode compare
  wire [5:0]  insn_prim = insn_in[31:26];
  wire [10:0] insn_ext  = insn_in[10:0];
  logic [NUM_ENTRIES-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < NUM_ENTRIES; g++)
    begin : g_match
      wire [10:0] ext  = entry_r[g][E_EXT_HI:E_EXT_LO];
      // bit0 selects opcode 4 over opcode 0
      wire [5:0]  prim = entry_r[g][E_PRIMARY] ? PRIM_OP4 : PRIM_OP0;
      // wildcard drops the upper five extended bits
      wire ext_ok = entry_r[g][E_WILD] ? (ext[5:0] == insn_ext[5:0])
                                       : (ext == insn_ext);
      assign hit[g] = entry_r[g][E_EN] && (prim == insn_prim) && ext_ok
                      && (entry_r[g][E_TYPE_HI:E_TYPE_LO] != TYPE_PTR);
    end
  endgenerate

  // lowest matching entry wins when several are programmed alike
  logic [3:0] hit_idx;
  always_comb
  begin
    hit_idx = 4'h0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--)
      if (hit[i])
        hit_idx = 4'(i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode controls
  wire [31:0] ent      = entry_r[hit_idx];
  // enable off overrides every disable and clears every flag and request; exec_type is still decoded
  wire enabled         = ctrl_r[C_ENABLE];
  wire any_udi_hit     = |hit;
  wire is_udi          = any_udi_hit && !is_custom_ldst_in;
  wire udi_illegal     = is_udi && ctrl_r[C_UDI_DIS];
  wire ldst_illegal    = is_custom_ldst_in && ctrl_r[C_LDST_DIS];
  wire fp_illegal      = is_fp_in && ctrl_r[C_FP_DIS];
  // per-class disable only when fp decode is on
  wire fp_unimpl       = is_fp_in && !ctrl_r[C_FP_DIS]
                         && |(fp_class_in & ctrl_r[C_FPC_HI:C_FPC_LO]);
  wire priv_bad        = !priv_mode_in
                         && ((is_udi && ent[E_PRIV])
                         || (is_custom_ldst_in && ctrl_r[C_LDST_PRV]));
  wire is_ldst         = is_custom_ldst_in || is_fp_ldst_in;
  // endian traps on coprocessor and fp storage access
  wire endian_bad      = is_ldst && ((little_endian_in && ctrl_r[C_LITTLE_ENDIAN_TRAP])
                         || (!little_endian_in && ctrl_r[C_BIG_ENDIAN_TRAP]));
  // natural alignment mask from transfer size
  wire [31:0] size_mask = ~((32'h0000_0001 << ldst_size_log2_in) - 32'h0000_0001);
  wire [31:0] addr_out  = ctrl_r[C_ALIGN] ? (ldst_addr_in & size_mask) : ldst_addr_in;

  // type from entry; force late confirm
  logic [1:0] type_sel;
  always_comb
  begin
    type_sel = TYPE_EARLY;
    if (is_udi)
      type_sel = ctrl_r[C_UDI_LATE] ? TYPE_LATE : ent[E_TYPE_HI:E_TYPE_LO];
    else if (is_fp_in && !is_fp_ldst_in && ctrl_r[C_FP_LATE])
      type_sel = TYPE_LATE;
  end

  wire claim = enabled && (is_udi || is_custom_ldst_in || is_fp_in);
  // operand and routing requests only for a custom instruction that really decodes,
  // so a disabled decoder never asks the register file for anything
  wire udi_ok = enabled && is_udi && !udi_illegal;

  ////////////////////////////////////////////////////////////////////////////
  // registered decode answer, one cycle after the instruction
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      result_r <= '0;
    else
    begin
      result_r.valid          <= insn_valid_in;
      result_r.claimed        <= insn_valid_in && claim;
      result_r.udi_hit        <= insn_valid_in && enabled && is_udi && !udi_illegal;
      result_r.illegal        <= insn_valid_in && enabled
                                 && (udi_illegal || ldst_illegal || fp_illegal);
      result_r.unimplemented  <= insn_valid_in && enabled && fp_unimpl;
      result_r.priv_violation <= insn_valid_in && enabled && priv_bad;
      result_r.endian_trap    <= insn_valid_in && enabled && endian_bad;
      result_r.first_source_operand  <= insn_valid_in && udi_ok && ent[E_SRC1];
      result_r.second_source_operand <= insn_valid_in && udi_ok && ent[E_SRC2];
      // result written back to target register
      result_r.target_register <= insn_valid_in && udi_ok && ent[E_TGT_WR];
      result_r.condition_return_enable <= insn_valid_in && udi_ok && ent[E_CR_EN];
      result_r.condition_field_select  <= ent[E_CRF_HI:E_CRF_LO];
      result_r.exec_type      <= type_sel;
      result_r.ldst_addr      <= addr_out;
    end
  end

  assign result_out = result_r;

  // permit waits for the writeback stage when asked
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      permit_r <= 1'b0;
    else
      permit_r <= ctrl_r[C_ST_WB] ? store_passed_lwb_in : store_issue_in;
  end

  assign store_commit_permit_out = permit_r;

endmodule : aidc_decode_config
`default_nettype wire

// File: testbench/aidc_sva.sv
// checker: bus, decode and store permit timing relations
`timescale 1ns/10ps
`default_nettype none
module aidc_sva
  import aidc_pkg::*;
(
  input wire logic              core_clk_in,
  input wire logic              rst_in,
  input wire logic [7:0]        dcr_addr_in,
  input wire logic              dcr_read_in,
  input wire logic              dcr_write_in,
  input wire logic [31:0]       dcr_rdata_out,
  input wire logic              dcr_ack_out,
  input wire logic              insn_valid_in,
  input wire logic              store_issue_in,
  input wire logic              store_passed_lwb_in,
  input wire aidc_pkg::aidc_result_t result_out,
  input wire logic              store_commit_permit_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // strobe to one of the two mapped offsets
  wire map_w = (dcr_read_in || dcr_write_in) &&
               (dcr_addr_in == ENTRY_OFFS || dcr_addr_in == CTRL_OFFS);
  a_ack_mapped: assert property (map_w |=> dcr_ack_out)
    else $error("mapped access not acknowledged");
  a_ack_unmapped: assert property (!map_w |=> !dcr_ack_out)
    else $error("acknowledge without mapped access");
  a_ctrl_read_mask: assert property (dcr_read_in && dcr_addr_in == CTRL_OFFS
    |=> (dcr_rdata_out & ~CTRL_MASK) == 32'h0) else $error("control read bits");
  a_entry_read_mask: assert property (dcr_read_in && dcr_addr_in == ENTRY_OFFS
    |=> (dcr_rdata_out & ~ENTRY_MASK) == 32'h0) else $error("entry reserved bits");
  a_result_valid: assert property (insn_valid_in |=> result_out.valid)
    else $error("decode answer missing");
  a_idle_quiet: assert property (!insn_valid_in |=>
    !result_out.udi_hit && !result_out.illegal && !result_out.unimplemented)
    else $error("decode flags without instruction");
  a_operand_qual: assert property (!result_out.udi_hit |-> !result_out.target_register
    && !result_out.first_source_operand && !result_out.condition_return_enable)
    else $error("operand routing without hit");
  a_permit_cause: assert property (!store_issue_in && !store_passed_lwb_in
    |=> !store_commit_permit_out) else $error("permit without store");
endmodule : aidc_sva
bind aidc_decode_config aidc_sva aidc_sva_i (.core_clk_in, .rst_in, .dcr_addr_in,
  .dcr_read_in, .dcr_write_in, .dcr_rdata_out, .dcr_ack_out, .insn_valid_in,
  .store_issue_in, .store_passed_lwb_in, .result_out, .store_commit_permit_out);
`default_nettype wire

// File: testbench/aidc_pipe_model.sv
// pipeline model: reports a store passing the writeback stage
`timescale 1ns/10ps
`default_nettype none
module aidc_pipe_model #(parameter int STAGE_LAG = 2)
(
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic store_issue_in,
  output logic      store_passed_out
);
  logic [STAGE_LAG-1:0] stage_r;
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in) stage_r <= '0;
    else stage_r <= {stage_r[STAGE_LAG-2:0], store_issue_in};
  end
  assign store_passed_out = stage_r[STAGE_LAG-1];
endmodule : aidc_pipe_model
`default_nettype wire

// File: testbench/tb_top.sv
// testbench: register access, decode and store permit scenarios
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import aidc_pkg::*;
  logic core_clk_in = 1'b0, rst_in = 1'b1, dcr_read_in = 1'b0, dcr_write_in = 1'b0;
  logic insn_valid_in = 1'b0, is_fp_in = 1'b0, store_issue_in = 1'b0;
  logic dcr_ack_out, store_passed_lwb_in, store_commit_permit_out;
  logic [7:0]  dcr_addr_in = 8'h00;
  logic [5:0]  fp_class_in = 6'h00;
  logic [31:0] dcr_wdata_in = 32'h0, insn_in = 32'h0, ldst_addr_in = 32'h0, dcr_rdata_out;
  logic [31:0] decode_control_tieoff_in = 32'hFFFF_FFFF, lfsr = 32'h09B0, ent, hit;
  logic [NUM_ENTRIES-1:0][31:0] entry_tieoff_first_in = '0;
  logic [11:0] dn;
  logic [31:0] rq[$];
  logic [11:0] dq[$];
  logic [3:0]  oq[$];
  logic [31:0] aq[$];
  logic        align_exp = 1'b0;
  aidc_result_t result_out;
  int fail_count = 0, check_count = 0, cyc = 0;
  aidc_decode_config aidc_decode_config_i (.core_clk_in, .rst_in, .dcr_addr_in,
    .dcr_read_in, .dcr_write_in, .dcr_wdata_in, .dcr_rdata_out, .dcr_ack_out,
    .decode_control_tieoff_in, .entry_tieoff_first_in, .insn_valid_in, .insn_in,
    .priv_mode_in(1'b1), .is_custom_ldst_in(1'b0), .is_fp_in, .is_fp_ldst_in(1'b0),
    .fp_class_in, .ldst_addr_in, .ldst_size_log2_in(3'h2), .little_endian_in(1'b0),
    .store_issue_in, .store_passed_lwb_in, .result_out, .store_commit_permit_out);
  aidc_pipe_model aidc_pipe_model_i (.core_clk_in, .rst_in, .store_issue_in,
    .store_passed_out(store_passed_lwb_in));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one register cycle; only mapped offsets leave a note
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, e);
    @(negedge core_clk_in);
    dcr_addr_in = a;
    dcr_write_in = wr;
    dcr_read_in = !wr;
    dcr_wdata_in = d;
    if (a == ENTRY_OFFS || a == CTRL_OFFS) rq.push_back(wr ? 32'h0 : e);
    @(negedge core_clk_in);
    dcr_write_in = 1'b0;
    dcr_read_in = 1'b0;
  endtask : bus
  // one instruction; note holds {mask, udi, illegal, unimpl, priv, type}
  task automatic dec(input logic [31:0] i, input logic f, input logic [5:0] c,
                     input logic [11:0] e);
    @(negedge core_clk_in);
    lfsr = lfsr_next(lfsr);
    ldst_addr_in = lfsr;
    insn_in = i;
    is_fp_in = f;
    fp_class_in = c;
    insn_valid_in = 1'b1;
    dq.push_back(e);
    oq.push_back((e[11] && e[5]) ?
      {ent[E_SRC1], ent[E_SRC2], ent[E_TGT_WR], ent[E_CR_EN]} : 4'h0);
    aq.push_back(align_exp ? (lfsr & 32'hFFFF_FFFC) : lfsr);
    @(negedge core_clk_in);
    insn_valid_in = 1'b0;
  endtask : dec
  // store permit arrives lag cycles after issue
  task automatic sp(input logic [31:0] c, input int lag);
    bus(CTRL_OFFS, 1'b1, c, 32'h0);
    @(negedge core_clk_in);
    store_issue_in = 1'b1;
    @(negedge core_clk_in);
    store_issue_in = 1'b0;
    chk("permit_early", {31'h0, store_commit_permit_out}, {31'h0, lag == 1});
    repeat (lag - 1) @(negedge core_clk_in);
    chk("permit", {31'h0, store_commit_permit_out}, 32'h1);
  endtask : sp
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////
  // clock and a hang limit well above the run length
  initial
  begin
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      give_verdict;
    end
  end
  // watcher: each answer takes the oldest note
  always @(negedge core_clk_in)
  begin
    if (dcr_ack_out === 1'b1)
    begin
      if (rq.size() == 0) chk("ack", 32'h1, 32'h0);
      else chk("rdata", dcr_rdata_out, rq.pop_front());
    end
    if (result_out.valid === 1'b1)
    begin
      dn = dq.pop_front();
      chk("decode", {26'h0, dn[11:6] & {result_out.udi_hit, result_out.illegal,
        result_out.unimplemented, result_out.priv_violation, result_out.exec_type}},
        {26'h0, dn[11:6] & dn[5:0]});
      chk("operands", {28'h0, result_out.first_source_operand,
        result_out.second_source_operand, result_out.target_register,
        result_out.condition_return_enable}, {28'h0, oq.pop_front()});
      chk("ldst_addr", result_out.ldst_addr, aq.pop_front());
    end
  end
  initial
  begin
    repeat (16) @(negedge core_clk_in);
    rst_in = 1'b0;
    bus(CTRL_OFFS, 1'b0, 32'h0, CTRL_MASK);
    bus(8'h06, 1'b1, 32'hFFFF_FFFF, 32'h0);
    bus(CTRL_OFFS, 1'b1, 32'h0000_0001, 32'h0);
    bus(CTRL_OFFS, 1'b0, 32'h0, 32'h0000_0001);
    // point at entry 3, then the early, late and autonomous types
    bus(ENTRY_OFFS, 1'b1, 32'h0000_00F0, 32'h0);
    for (int t = 0; t < 3; t++)
    begin
      lfsr = lfsr_next(lfsr);
      ent = (lfsr & ENTRY_MASK & ~32'h0008_0032) | {26'h0, t[1:0], 4'h1};
      bus(ENTRY_OFFS, 1'b1, ent, 32'h0);
      bus(ENTRY_OFFS, 1'b0, 32'h0, ent);
      hit = {ent[31] ? PRIM_OP4 : PRIM_OP0, 15'h0, ent[30:20]};
      dec(hit, 1'b0, 6'h00, {6'h3F, 4'h8, t[1:0]});
      dec(hit ^ 32'h40, 1'b0, 6'h00, {6'h20, 6'h00});
    end
    bus(ENTRY_OFFS, 1'b1, ent | 32'h2, 32'h0);
    dec(hit ^ 32'h40, 1'b0, 6'h00, {6'h3F, 4'h8, TYPE_AUTO});
    bus(CTRL_OFFS, 1'b1, 32'h0100_0001, 32'h0);
    dec(hit, 1'b0, 6'h00, {6'h3F, 4'h8, TYPE_LATE});
    bus(CTRL_OFFS, 1'b1, 32'h0200_0001, 32'h0);
    dec(hit, 1'b0, 6'h00, {6'h10, 6'h10});
    bus(CTRL_OFFS, 1'b1, 32'h0080_0001, 32'h0);
    dec(32'hFC00_0000, 1'b1, 6'h00, {6'h10, 6'h10});
    bus(CTRL_OFFS, 1'b1, 32'h0040_0001, 32'h0);
    dec(32'hFC00_0000, 1'b1, 6'h20, {6'h18, 6'h08});
    bus(CTRL_OFFS, 1'b1, 32'h0, 32'h0);
    dec(hit, 1'b0, 6'h00, {6'h3C, 6'h00});
    sp(32'h0000_0001, 1);
    sp(32'h0000_8001, 3);
    // forced alignment on a word transfer clears the two low address bits
    align_exp = 1'b1;
    bus(CTRL_OFFS, 1'b1, 32'h0000_0801, 32'h0);
    dec(32'hFC00_0000, 1'b1, 6'h00, {6'h10, 6'h00});
    align_exp = 1'b0;
    // restore pulse brings back tie-off values and pointer 0
    bus(CTRL_OFFS, 1'b1, 32'h8000_0000, 32'h0);
    bus(CTRL_OFFS, 1'b0, 32'h0, CTRL_MASK);
    bus(ENTRY_OFFS, 1'b0, 32'h0, 32'h0);
    repeat (2) @(negedge core_clk_in);
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
